// ### rtl/icr_config_regs.sv
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module icr_config_regs
   import icr_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // operating mode: 1 shared memory, 0 host dma
   input  wire logic        shared_mode_i,
   // subsystem interrupt requests and infrared activity
   input  wire logic        uart_irq_i,
   input  wire logic        fir_irq_i,
   input  wire logic        ir_traffic_i,
   input  wire logic        power_down_i,
   // host address decode
   input  wire logic [15:0] io_addr_i,
   input  wire logic [19:0] mem_addr_i,
   output logic             uart_sel_o,
   output logic             fir_sel_o,
   output logic             mem_win_sel_o,
   // dma routing
   input  wire logic        internal_dma_req_one_i,
   input  wire logic        internal_dma_req_two_i,
   input  wire logic [3:0]  dma_ack_i,
   output logic      [3:0]  dma_request_out_o,
   output logic             internal_ack_one_o,
   output logic             internal_ack_two_o,
   // interrupt pins
   output logic             irq3_o,
   output logic             irq4_o,
   output logic             uart_irq_pin_o,
   output logic             fast_ir_irq_pin_o,
   // core control
   output logic             sub_reset_o,
   output logic             core_enable_o,
   output logic             transceiver_off_out_o,
   output logic             wake_pending_o
);

   function automatic logic [3:0] onehot4(input logic [1:0] sel);
      onehot4 = 4'h1 << sel;
   endfunction

   // one write strobe per register index
   function automatic logic wr_hit(input logic       wr,
                                   input logic [2:0] addr,
                                   input logic [2:0] idx);
      wr_hit = wr && (addr == idx);
   endfunction

   // pulse generator states, one-hot
   typedef enum logic [1:0] {
      PS_IDLE = 2'b01,
      PS_LOW  = 2'b10
   } icr_pulse_state_t;

   localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(PULSE_LEN);
   localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(1);

   // configuration storage
   logic [7:0] ctl_q;
   logic [7:0] uart_lo_q;
   logic [7:0] uart_hi_q;
   logic [7:0] fir_lo_q;
   logic [7:0] fir_hi_q;
   logic [7:0] dma_map_q;
   logic [7:0] win_base_q;

   logic [7:0]             rdata_q;
   logic                   wake_q;
   logic                   req_prev_q;
   logic [PULSE_CNT_W-1:0] pulse_cnt_q;
   icr_pulse_state_t       pulse_state_q;
   logic [3:0]             pins_q;
   logic                   uart_sel_q;
   logic                   fir_sel_q;
   logic                   mem_sel_q;
   logic [3:0]             drq_q;
   logic                   ack_one_q;
   logic                   ack_two_q;

   // write decode
   wire wr_ctl     = wr_hit(reg_wr_i, reg_addr_i, IDX_MAIN_CTL);
   wire wr_uart_lo = wr_hit(reg_wr_i, reg_addr_i, IDX_UART_LO);
   wire wr_uart_hi = wr_hit(reg_wr_i, reg_addr_i, IDX_UART_HI);
   wire wr_fir_lo  = wr_hit(reg_wr_i, reg_addr_i, IDX_FIR_LO);
   wire wr_fir_hi  = wr_hit(reg_wr_i, reg_addr_i, IDX_FIR_HI);
   wire wr_idx7    = wr_hit(reg_wr_i, reg_addr_i, IDX_DMA_WIN);
   wire wr_dma_map = wr_idx7 && !shared_mode_i;
   wire wr_win     = wr_idx7 && shared_mode_i;

   // control fields
   wire       soft_rst   = ctl_q[CTL_SRST];
   wire       level_mode = ctl_q[CTL_LEVEL];
   wire       adv_mode   = ctl_q[CTL_ADV];
   wire [1:0] adv_sel    = ctl_q[CTL_SEL_HI:CTL_SEL_LO];
   wire       ir_enable  = ctl_q[CTL_IREN];

   // read mux
   logic [7:0] rdata_d;
   always_comb begin
      case (reg_addr_i)
         IDX_MODE_ID:  rdata_d = shared_mode_i ? ID_SHM_MODE : ID_DMA_MODE;
         IDX_FIXED_ID: rdata_d = ID_FIXED;
         IDX_MAIN_CTL: rdata_d = ctl_q;
         IDX_UART_LO:  rdata_d = uart_lo_q;
         IDX_UART_HI:  rdata_d = uart_hi_q;
         IDX_FIR_LO:   rdata_d = fir_lo_q;
         IDX_FIR_HI:   rdata_d = fir_hi_q;
         IDX_DMA_WIN:  rdata_d = shared_mode_i ? win_base_q : dma_map_q;
         default:      rdata_d = 8'h00;
      endcase
   end

   // register file; not touched by soft reset, which only resets subsystems
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q <= CTL_RST;
      end else if (wr_ctl) begin
         ctl_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uart_lo_q <= BASE_RST;
      end else if (wr_uart_lo) begin
         uart_lo_q <= reg_wdata_i & BASE_LOW_MASK;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uart_hi_q <= BASE_RST;
      end else if (wr_uart_hi) begin
         uart_hi_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fir_lo_q <= BASE_RST;
      end else if (wr_fir_lo) begin
         fir_lo_q <= reg_wdata_i & BASE_LOW_MASK;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fir_hi_q <= BASE_RST;
      end else if (wr_fir_hi) begin
         fir_hi_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dma_map_q <= DMA_MAP_RST;
      end else if (wr_dma_map) begin
         dma_map_q <= reg_wdata_i & DMA_MAP_MASK;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_base_q <= WIN_BASE_RST;
      end else if (wr_win) begin
         win_base_q <= reg_wdata_i & WIN_BASE_MASK;
      end
   end

   // read data valid only the cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd_i ? rdata_d : 8'h00;
      end
   end

   // wakeup: sticky while powered down; leaving power down clears it, traffic or not
   wire wake_set = ctl_q[CTL_WAKE] && power_down_i && ir_traffic_i;
   wire wake_d   = wake_set || (wake_q && power_down_i);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
      end
   end

   // interrupt routing
   wire fir_req    = fir_irq_i || wake_q;
   wire merged_req = uart_irq_i || fir_req;
   wire req_rise   = merged_req && !req_prev_q;
   wire pulse_on   = (pulse_state_q == PS_LOW);
   wire [3:0] route = onehot4(adv_sel);

   // pulse stretcher; a new request during a pulse is absorbed
   logic [PULSE_CNT_W-1:0] pulse_cnt_d;
   icr_pulse_state_t       pulse_state_d;
   always_comb begin
      pulse_state_d = pulse_state_q;
      pulse_cnt_d   = pulse_cnt_q;
      case (pulse_state_q)
         PS_IDLE: begin
            if (req_rise && adv_mode && !level_mode) begin
               pulse_state_d = PS_LOW;
               pulse_cnt_d   = PULSE_LOAD;
            end
         end
         PS_LOW: begin
            pulse_cnt_d = pulse_cnt_q - 1'b1;
            if (pulse_cnt_q == PULSE_LAST) begin
               pulse_state_d = PS_IDLE;
            end
         end
         default: begin
            pulse_state_d = PS_IDLE;
            pulse_cnt_d   = '0;
         end
      endcase
   end

   // pin levels, index order matches the routing field
   logic [3:0] pins_d;
   always_comb begin
      if (adv_mode) begin
         if (level_mode) begin
            pins_d = ~(route & {4{merged_req}});
         end else begin
            pins_d = ~(route & {4{pulse_on}});
         end
      end else begin
         pins_d = {fir_req, uart_irq_i, 2'b00};
      end
   end

   // idle low: a request held through reset reads as a rise, but adv_mode is still clear then so no pulse starts
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_prev_q <= 1'b0;
      end else begin
         req_prev_q <= merged_req;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_state_q <= PS_IDLE;
      end else begin
         pulse_state_q <= pulse_state_d;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_cnt_q <= '0;
      end else begin
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_q <= 4'h0;
      end else begin
         pins_q <= pins_d;
      end
   end

   // address decode; uart and fir selects hidden while soft reset is held, the memory window select is not
   wire uart_hit = (io_addr_i[15:3] == {uart_hi_q, uart_lo_q[7:3]});
   wire fir_hit  = (io_addr_i[15:3] == {fir_hi_q, fir_lo_q[7:3]});
   wire mem_hit  = shared_mode_i && ctl_q[CTL_MEMWIN]
                   && (mem_addr_i[19:13] == win_base_q[7:1]);

   // dma mapping
   wire [3:0] drq_one = onehot4(dma_map_q[1:0]) & {4{internal_dma_req_one_i}};
   wire [3:0] drq_two = onehot4(dma_map_q[3:2]) & {4{internal_dma_req_two_i}};

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uart_sel_q <= 1'b0;
      end else begin
         uart_sel_q <= uart_hit && !soft_rst;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fir_sel_q <= 1'b0;
      end else begin
         fir_sel_q <= fir_hit && !soft_rst;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_sel_q <= 1'b0;
      end else begin
         mem_sel_q <= mem_hit;
      end
   end

   // two requests mapped to one pair share that request pin
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drq_q <= 4'h0;
      end else begin
         drq_q <= drq_one | drq_two;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_one_q <= 1'b0;
      end else begin
         ack_one_q <= dma_ack_i[dma_map_q[1:0]];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_two_q <= 1'b0;
      end else begin
         ack_two_q <= dma_ack_i[dma_map_q[3:2]];
      end
   end

   // core control flops
   logic sub_reset_q;
   logic core_en_q;
   logic xcvr_off_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_reset_q <= 1'b0;
      end else begin
         sub_reset_q <= soft_rst;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_en_q <= 1'b0;
      end else begin
         core_en_q <= ir_enable;
      end
   end

   // transceiver stays powered off until software enables the core
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xcvr_off_q <= 1'b1;
      end else begin
         xcvr_off_q <= !ir_enable;
      end
   end

   assign reg_rdata_o           = rdata_q;
   assign irq3_o                = pins_q[PIN_IRQ3];
   assign irq4_o                = pins_q[PIN_IRQ4];
   assign uart_irq_pin_o        = pins_q[PIN_UART];
   assign fast_ir_irq_pin_o     = pins_q[PIN_FIR];
   assign uart_sel_o            = uart_sel_q;
   assign fir_sel_o             = fir_sel_q;
   assign mem_win_sel_o         = mem_sel_q;
   assign dma_request_out_o     = drq_q;
   assign internal_ack_one_o    = ack_one_q;
   assign internal_ack_two_o    = ack_two_q;
   assign sub_reset_o           = sub_reset_q;
   assign core_enable_o         = core_en_q;
   assign transceiver_off_out_o = xcvr_off_q;
   assign wake_pending_o        = wake_q;

endmodule // icr_config_regs

// ### rtl/icr_pkg.sv
package icr_pkg;

   // register indices
   localparam logic [2:0] IDX_MODE_ID   = 3'h0;
   localparam logic [2:0] IDX_FIXED_ID  = 3'h1;
   localparam logic [2:0] IDX_MAIN_CTL  = 3'h2;
   localparam logic [2:0] IDX_UART_LO   = 3'h3;
   localparam logic [2:0] IDX_UART_HI   = 3'h4;
   localparam logic [2:0] IDX_FIR_LO    = 3'h5;
   localparam logic [2:0] IDX_FIR_HI    = 3'h6;
   localparam logic [2:0] IDX_DMA_WIN   = 3'h7;

   // main_control fields
   localparam int CTL_LEVEL   = 7;
   localparam int CTL_SRST    = 6;
   localparam int CTL_WAKE    = 5;
   localparam int CTL_ADV     = 4;
   localparam int CTL_SEL_HI  = 3;
   localparam int CTL_SEL_LO  = 2;
   localparam int CTL_MEMWIN  = 1;
   localparam int CTL_IREN    = 0;

   // writable bit masks, reserved bits are zero
   localparam logic [7:0] BASE_LOW_MASK = 8'hF8;
   localparam logic [7:0] DMA_MAP_MASK  = 8'h0F;
   localparam logic [7:0] WIN_BASE_MASK = 8'hFE;

   // reset values
   localparam logic [7:0] CTL_RST       = 8'h00;
   localparam logic [7:0] BASE_RST      = 8'h00;
   localparam logic [7:0] DMA_MAP_RST   = 8'h00;
   localparam logic [7:0] WIN_BASE_RST  = 8'h00;

   // identity codes, values arbitrary
   localparam logic [7:0] ID_DMA_MODE   = 8'h5A;
   localparam logic [7:0] ID_SHM_MODE   = 8'h5B;
   localparam logic [7:0] ID_FIXED      = 8'hA5;

   // interrupt pin numbering for the routing field
   localparam logic [1:0] PIN_IRQ3      = 2'h0;
   localparam logic [1:0] PIN_IRQ4      = 2'h1;
   localparam logic [1:0] PIN_UART      = 2'h2;
   localparam logic [1:0] PIN_FIR       = 2'h3;

   // pulse interrupt timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int PULSE_MIN_NS   = 500000;
   localparam int PULSE_MAX_NS   = 1000000;
   localparam int PULSE_CYCLES   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MAX_CYC  = PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W    = 14;

endpackage

// ### test/icr_config_regs_asserts.sv
`timescale 1ns/10ps
module icr_config_regs_chk
   import icr_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYCLES
) (
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       shared_mode_i,
   input wire logic       uart_irq_i,
   input wire logic       fir_irq_i,
   input wire logic       internal_dma_req_one_i,
   input wire logic       internal_dma_req_two_i,
   input wire logic [3:0] dma_request_out_o,
   input wire logic       irq3_o,
   input wire logic       irq4_o,
   input wire logic       uart_irq_pin_o,
   input wire logic       fast_ir_irq_pin_o,
   input wire logic       sub_reset_o,
   input wire logic       core_enable_o,
   input wire logic       transceiver_off_out_o,
   input wire logic       wake_pending_o,
   input wire logic       uart_sel_o,
   input wire logic       fir_sel_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] ctl_m;
   logic [3:0] map_m;
   logic [3:0] pins;
   logic       all_hi;
   logic       mrg;
   int         low_n;
   assign pins = {fast_ir_irq_pin_o, uart_irq_pin_o, irq4_o, irq3_o};
   assign all_hi = &pins;
   assign mrg = uart_irq_i | fir_irq_i | wake_pending_o;
   // shadow copies of the control and map registers, seen from the bus side
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_m <= 8'h00;
         map_m <= 4'h0;
         low_n <= 0;
      end else begin
         if (reg_wr_i && reg_addr_i == IDX_MAIN_CTL) ctl_m <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == IDX_DMA_WIN && !shared_mode_i) map_m <= reg_wdata_i[3:0];
         low_n <= (all_hi || !ctl_m[CTL_ADV]) ? 0 : low_n + 1;
      end
   end
   AST_MODE_ID: assert property ($past(reg_rd_i) && $past(reg_addr_i) == IDX_MODE_ID |->
      reg_rdata_o == ($past(shared_mode_i) ? ID_SHM_MODE : ID_DMA_MODE)) else $error("mode id");
   AST_FIXED_ID: assert property ($past(reg_rd_i) && $past(reg_addr_i) == IDX_FIXED_ID |->
      reg_rdata_o == ID_FIXED) else $error("fixed id");
   AST_SRST: assert property (sub_reset_o == $past(ctl_m[CTL_SRST])) else $error("soft reset");
   AST_BLOCK: assert property (sub_reset_o |-> !uart_sel_o && !fir_sel_o) else $error("blocked");
   AST_XCVR: assert property (transceiver_off_out_o == !core_enable_o &&
      core_enable_o == $past(ctl_m[CTL_IREN])) else $error("core enable");
   AST_PLAIN: assert property (!$past(ctl_m[CTL_ADV]) |-> !irq3_o && !irq4_o &&
      uart_irq_pin_o == $past(uart_irq_i) &&
      fast_ir_irq_pin_o == ($past(fir_irq_i) | $past(wake_pending_o))) else $error("plain irq");
   AST_LEVEL: assert property ($past(ctl_m[CTL_ADV]) && $past(ctl_m[CTL_LEVEL]) |->
      pins == ($past(mrg) ? ~(4'h1 << $past(ctl_m[3:2])) : 4'hF)) else $error("level irq");
   AST_PULSE: assert property ($rose(all_hi) && $past(ctl_m[CTL_ADV], 2) &&
      !$past(ctl_m[CTL_LEVEL]) |-> low_n == PULSE_LEN) else $error("pulse length");
   AST_DMA: assert property (dma_request_out_o ==
      ((4'($past(internal_dma_req_one_i)) << $past(map_m[1:0])) |
       (4'($past(internal_dma_req_two_i)) << $past(map_m[3:2])))) else $error("dma map");
endmodule // icr_config_regs_chk

// ### test/icr_host_model.sv
`timescale 1ns/10ps
module icr_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic [3:0] drq_i,
   output logic      [2:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [3:0] dack_o
);
   initial begin
      addr_o = 3'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      dack_o = 4'h0;
   end
   // dma controller grants one cycle after each request
   always @(posedge clk_sys_i) dack_o <= drq_i;
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      @(posedge clk_sys_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_sys_i);
      rd_o <= 1'b0;
      // data stand only in this cycle; sample once settled
      #1;
      q = rdata_i;
   endtask
endmodule // icr_host_model

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import icr_pkg::*;
   localparam int PLEN = 8;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [2:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i, reg_rdata_o;
   logic        reg_wr_i, reg_rd_i, shared_mode_i = 1'b0;
   logic        uart_irq_i = 1'b0, fir_irq_i = 1'b0, ir_traffic_i = 1'b0, power_down_i = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic [19:0] mem_addr_i = 20'h00000;
   logic        internal_dma_req_one_i = 1'b0, internal_dma_req_two_i = 1'b0;
   logic [3:0]  dma_ack_i, dma_request_out_o, pins;
   logic        uart_sel_o, fir_sel_o, mem_win_sel_o, internal_ack_one_o, internal_ack_two_o;
   logic        irq3_o, irq4_o, uart_irq_pin_o, fast_ir_irq_pin_o;
   logic        sub_reset_o, core_enable_o, transceiver_off_out_o, wake_pending_o;
   int          errors = 0, tests_run = 0, cycles = 0;
   assign pins = {fast_ir_irq_pin_o, uart_irq_pin_o, irq4_o, irq3_o};
   always #50 clk_sys_i = ~clk_sys_i;
   icr_config_regs #(.PULSE_LEN(PLEN)) dut (.*);
   icr_host_model host (
      .clk_sys_i (clk_sys_i),
      .rdata_i   (reg_rdata_o),
      .drq_i     (dma_request_out_o),
      .addr_o    (reg_addr_i),
      .wdata_o   (reg_wdata_i),
      .wr_o      (reg_wr_i),
      .rd_o      (reg_rd_i),
      .dack_o    (dma_ack_i)
   );
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] q;
      host.rd(a, q);
      chk("read data", exp, q);
   endtask
   // outputs are registered: one edge to land, one spare
   task automatic settle;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic t_ident;
      chk("xcvr off", 8'h01, 8'(transceiver_off_out_o));
      rdchk(IDX_MODE_ID, ID_DMA_MODE);
      @(posedge clk_sys_i) shared_mode_i <= 1'b1;
      rdchk(IDX_MODE_ID, ID_SHM_MODE);
      host.wr(IDX_FIXED_ID, 8'h00);
      rdchk(IDX_FIXED_ID, ID_FIXED);
      $display("ident done");
   endtask
   task automatic t_mask;
      host.wr(IDX_DMA_WIN, 8'hFF);
      rdchk(IDX_DMA_WIN, 8'hFE);
      @(posedge clk_sys_i) shared_mode_i <= 1'b0;
      rdchk(IDX_DMA_WIN, DMA_MAP_RST);
      host.wr(IDX_DMA_WIN, 8'hFF);
      rdchk(IDX_DMA_WIN, 8'h0F);
      host.wr(IDX_UART_LO, 8'hFF);
      rdchk(IDX_UART_LO, 8'hF8);
      host.wr(IDX_FIR_LO, 8'hFF);
      rdchk(IDX_FIR_LO, 8'hF8);
      $display("mask done");
   endtask
   task automatic t_decode;
      host.wr(IDX_UART_LO, 8'hA8);
      host.wr(IDX_UART_HI, 8'h12);
      host.wr(IDX_FIR_LO, 8'h30);
      host.wr(IDX_FIR_HI, 8'h45);
      @(posedge clk_sys_i) io_addr_i <= 16'h12AF;
      settle;
      chk("uart sel", 8'h01, 8'(uart_sel_o));
      @(posedge clk_sys_i) io_addr_i <= 16'h4537;
      settle;
      chk("fir sel", 8'h01, 8'(fir_sel_o));
      chk("uart sel", 8'h00, 8'(uart_sel_o));
      host.wr(IDX_MAIN_CTL, 8'h40); // hold kept short, the block never times it
      settle;
      chk("sub reset", 8'h01, 8'(sub_reset_o));
      chk("fir sel", 8'h00, 8'(fir_sel_o));
      host.wr(IDX_MAIN_CTL, 8'h00);
      rdchk(IDX_FIR_HI, 8'h45);
      chk("fir sel", 8'h01, 8'(fir_sel_o));
      $display("decode done");
   endtask
   task automatic t_window;
      @(posedge clk_sys_i) shared_mode_i <= 1'b1;
      host.wr(IDX_DMA_WIN, 8'hA4);
      host.wr(IDX_MAIN_CTL, 8'h02);
      @(posedge clk_sys_i) mem_addr_i <= 20'hA5FFF;
      settle;
      chk("window sel", 8'h01, 8'(mem_win_sel_o));
      @(posedge clk_sys_i) shared_mode_i <= 1'b0;
      settle;
      chk("window sel", 8'h00, 8'(mem_win_sel_o));
      host.wr(IDX_DMA_WIN, 8'h06);
      @(posedge clk_sys_i) internal_dma_req_one_i <= 1'b1;
      settle;
      settle;
      chk("dma req", 8'h04, 8'(dma_request_out_o));
      chk("dma ack", 8'h01, 8'(internal_ack_one_o));
      @(posedge clk_sys_i) internal_dma_req_two_i <= 1'b1;
      settle;
      chk("dma req", 8'h06, 8'(dma_request_out_o));
      settle;
      chk("dma ack", 8'h01, 8'(internal_ack_two_o));
      $display("window dma done");
   endtask
   task automatic t_irq;
      int n;
      host.wr(IDX_MAIN_CTL, 8'h01);
      @(posedge clk_sys_i) uart_irq_i <= 1'b1;
      settle;
      chk("pins", 8'h04, 8'(pins));
      chk("xcvr off", 8'h00, 8'(transceiver_off_out_o));
      chk("core en", 8'h01, 8'(core_enable_o));
      for (int s = 0; s < 4; s++) begin
         host.wr(IDX_MAIN_CTL, 8'h90 | 8'(s << 2));
         settle;
         chk("pins", 8'(4'hF ^ (4'h1 << s)), 8'(pins));
      end
      @(posedge clk_sys_i) uart_irq_i <= 1'b0;
      host.wr(IDX_MAIN_CTL, 8'h10);
      settle;
      @(posedge clk_sys_i) fir_irq_i <= 1'b1;
      n = 0;
      repeat (PLEN + 6) begin
         @(posedge clk_sys_i);
         #1;
         n += (irq3_o === 1'b0);
      end
      chk("pulse len", 8'(PLEN), 8'(n));
      @(posedge clk_sys_i) fir_irq_i <= 1'b0;
      host.wr(IDX_MAIN_CTL, 8'h20);
      @(posedge clk_sys_i) power_down_i <= 1'b1;
      @(posedge clk_sys_i) ir_traffic_i <= 1'b1;
      @(posedge clk_sys_i) ir_traffic_i <= 1'b0;
      settle;
      chk("pins", 8'h08, 8'(pins));
      chk("wake", 8'h01, 8'(wake_pending_o));
      @(posedge clk_sys_i) power_down_i <= 1'b0;
      settle;
      chk("pins", 8'h00, 8'(pins));
      chk("wake", 8'h00, 8'(wake_pending_o));
      $display("irq done");
   endtask
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         final_report;
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_ident;
      t_mask;
      t_decode;
      t_window;
      t_irq;
      final_report;
   end
endmodule // testbench
bind icr_config_regs icr_config_regs_chk #(.PULSE_LEN(PULSE_LEN)) u_chk (.*);
